// ==== rtl/ext_event_source_select.sv ====
// External event line source selector with its register port
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "ext_event_source_select_defs.svh"

module ext_event_source_select
   import ext_event_source_select_pkg::*;
(
   input  wire logic       I_MCLK,
   input  wire logic       I_RST_B,
   input  wire bus_addr_t  I_ADDR,
   input  wire bus_data_t  I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output var  bus_data_t  O_RDATA,
   input  wire port_pins_s I_PORT_PINS,
   output var  pin_group_t O_EVENT_LINE
);

   localparam logic [1:0] REG_NONE = 2'h3;

   // ========================================================================
   // Helpers
   function automatic logic [1:0] reg_index(input bus_addr_t addr);
      logic [1:0] idx;
      idx = REG_NONE;
      case (addr)
         `EVSS_OFS_LINES_0_3:  idx = 2'h0;
         `EVSS_OFS_LINES_4_7:  idx = 2'h1;
         `EVSS_OFS_LINES_8_11: idx = 2'h2;
         default:              idx = REG_NONE;
      endcase
      return idx;
   endfunction : reg_index

   function automatic logic select_pin(input port_sel_t sel, input pin_cands_t cands);
      logic lvl;
      lvl = 1'b0;
      case (sel)
         `EVSS_CODE_PORT_A: lvl = cands[0];
         `EVSS_CODE_PORT_B: lvl = cands[1];
         `EVSS_CODE_PORT_C: lvl = cands[2];
         `EVSS_CODE_PORT_D: lvl = cands[3];
         `EVSS_CODE_PORT_E: lvl = cands[4];
         `EVSS_CODE_PORT_F: lvl = cands[5];
         `EVSS_CODE_PORT_G: lvl = cands[6];
         // Reserved codes hold the line low
         default:           lvl = 1'b0;
      endcase
      return lvl;
   endfunction : select_pin

   function automatic pin_cands_t gather_candidates(input port_pins_s  pins,
                                                    input int unsigned n);
      pin_cands_t c;
      c    = '0;
      c[0] = pins.port_a[n];
      c[1] = pins.port_b[n];
      c[2] = pins.port_c[n];
      c[3] = pins.port_d[n];
      c[4] = pins.port_e[n];
      c[5] = pins.port_f[n];
      c[6] = pins.port_g[n];
      return c;
   endfunction : gather_candidates

   function automatic bus_data_t read_word(input sel_fields_s word);
      bus_data_t w;
      w = {`EVSS_RSVD_READ, word};
      return w;
   endfunction : read_word

   function automatic sel_fields_s write_word(input bus_data_t data);
      sel_fields_s f;
      // Upper half is not stored; writes to it are dropped
      f = sel_fields_s'(data[`EVSS_FIELDS_WIDTH-1:0]);
      return f;
   endfunction : write_word

   // ========================================================================
   // Pin synchronisation
   port_pins_s pins_sync;

   pin_level_sync u_pin_sync (
      .i_clk   (I_MCLK),
      .i_rst_b (I_RST_B),
      .i_pins  (I_PORT_PINS),
      .o_pins  (pins_sync)
   );

   // ========================================================================
   // Address decode
   logic [1:0] acc_idx;
   logic       wr_lines_0_3;
   logic       wr_lines_4_7;
   logic       wr_lines_8_11;
   logic       rd_lines_0_3;
   logic       rd_lines_4_7;
   logic       rd_lines_8_11;

   always_comb begin
      // Unmapped offsets raise no strobe
      acc_idx       = reg_index(I_ADDR);
      wr_lines_0_3  = I_WR && (acc_idx == 2'h0);
      wr_lines_4_7  = I_WR && (acc_idx == 2'h1);
      wr_lines_8_11 = I_WR && (acc_idx == 2'h2);
      rd_lines_0_3  = I_RD && (acc_idx == 2'h0);
      rd_lines_4_7  = I_RD && (acc_idx == 2'h1);
      rd_lines_8_11 = I_RD && (acc_idx == 2'h2);
   end

   // ========================================================================
   // Selectors for lines 0 to 3
   sel_fields_s event_source_select_lines_0_3_q;
   sel_fields_s event_source_select_lines_0_3_d;

   always_comb begin
      event_source_select_lines_0_3_d = event_source_select_lines_0_3_q;
      if (wr_lines_0_3) begin
         event_source_select_lines_0_3_d = write_word(I_WDATA);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         event_source_select_lines_0_3_q <= `EVSS_SEL_RESET;
      end else begin
         event_source_select_lines_0_3_q <= event_source_select_lines_0_3_d;
      end
   end

   // ========================================================================
   // Selectors for lines 4 to 7
   sel_fields_s event_source_select_lines_4_7_q;
   sel_fields_s event_source_select_lines_4_7_d;

   always_comb begin
      event_source_select_lines_4_7_d = event_source_select_lines_4_7_q;
      if (wr_lines_4_7) begin
         event_source_select_lines_4_7_d = write_word(I_WDATA);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         event_source_select_lines_4_7_q <= `EVSS_SEL_RESET;
      end else begin
         event_source_select_lines_4_7_q <= event_source_select_lines_4_7_d;
      end
   end

   // ========================================================================
   // Selectors for lines 8 to 11
   sel_fields_s event_source_select_lines_8_11_q;
   sel_fields_s event_source_select_lines_8_11_d;

   always_comb begin
      event_source_select_lines_8_11_d = event_source_select_lines_8_11_q;
      if (wr_lines_8_11) begin
         event_source_select_lines_8_11_d = write_word(I_WDATA);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         event_source_select_lines_8_11_q <= `EVSS_SEL_RESET;
      end else begin
         event_source_select_lines_8_11_q <= event_source_select_lines_8_11_d;
      end
   end

   // ========================================================================
   // Read port
   bus_data_t rdata_q;
   bus_data_t rdata_d;

   always_comb begin
      // Read data stand for exactly one cycle, zero otherwise
      rdata_d = `EVSS_RDATA_RESET;
      if (rd_lines_0_3) begin
         rdata_d = read_word(event_source_select_lines_0_3_q);
      end
      if (rd_lines_4_7) begin
         rdata_d = read_word(event_source_select_lines_4_7_q);
      end
      if (rd_lines_8_11) begin
         rdata_d = read_word(event_source_select_lines_8_11_q);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         rdata_q <= `EVSS_RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign O_RDATA = rdata_q;

   // ========================================================================
   // Per-line selector fields
   port_sel_t line0_port_select;
   port_sel_t line1_port_select;
   port_sel_t line2_port_select;
   port_sel_t line3_port_select;
   port_sel_t line4_port_select;
   port_sel_t line5_port_select;
   port_sel_t line6_port_select;
   port_sel_t line7_port_select;
   port_sel_t line8_port_select;
   port_sel_t line9_port_select;
   port_sel_t line10_port_select;
   port_sel_t line11_port_select;

   always_comb begin
      line0_port_select  = event_source_select_lines_0_3_q.sel_lo;
      line1_port_select  = event_source_select_lines_0_3_q.sel_mid_lo;
      line2_port_select  = event_source_select_lines_0_3_q.sel_mid_hi;
      line3_port_select  = event_source_select_lines_0_3_q.sel_hi;

      line4_port_select  = event_source_select_lines_4_7_q.sel_lo;
      line5_port_select  = event_source_select_lines_4_7_q.sel_mid_lo;
      line6_port_select  = event_source_select_lines_4_7_q.sel_mid_hi;
      line7_port_select  = event_source_select_lines_4_7_q.sel_hi;

      line8_port_select  = event_source_select_lines_8_11_q.sel_lo;
      line9_port_select  = event_source_select_lines_8_11_q.sel_mid_lo;
      line10_port_select = event_source_select_lines_8_11_q.sel_mid_hi;
      line11_port_select = event_source_select_lines_8_11_q.sel_hi;
   end

   // ========================================================================
   // Same-numbered pins of ports A to G, one group per line
   pin_cands_t cands_line0;
   pin_cands_t cands_line1;
   pin_cands_t cands_line2;
   pin_cands_t cands_line3;
   pin_cands_t cands_line4;
   pin_cands_t cands_line5;
   pin_cands_t cands_line6;
   pin_cands_t cands_line7;
   pin_cands_t cands_line8;
   pin_cands_t cands_line9;
   pin_cands_t cands_line10;
   pin_cands_t cands_line11;

   always_comb begin
      cands_line0  = gather_candidates(pins_sync, 0);
      cands_line1  = gather_candidates(pins_sync, 1);
      cands_line2  = gather_candidates(pins_sync, 2);
      cands_line3  = gather_candidates(pins_sync, 3);
      cands_line4  = gather_candidates(pins_sync, 4);
      cands_line5  = gather_candidates(pins_sync, 5);
      cands_line6  = gather_candidates(pins_sync, 6);
      cands_line7  = gather_candidates(pins_sync, 7);
      cands_line8  = gather_candidates(pins_sync, 8);
      cands_line9  = gather_candidates(pins_sync, 9);
      cands_line10 = gather_candidates(pins_sync, 10);
      cands_line11 = gather_candidates(pins_sync, 11);
   end

   // ========================================================================
   // Event line multiplexer
   pin_group_t event_d;
   pin_group_t event_q;

   always_comb begin
      event_d     = '0;
      event_d[0]  = select_pin(line0_port_select, cands_line0);
      event_d[1]  = select_pin(line1_port_select, cands_line1);
      event_d[2]  = select_pin(line2_port_select, cands_line2);
      event_d[3]  = select_pin(line3_port_select, cands_line3);
      event_d[4]  = select_pin(line4_port_select, cands_line4);
      event_d[5]  = select_pin(line5_port_select, cands_line5);
      event_d[6]  = select_pin(line6_port_select, cands_line6);
      event_d[7]  = select_pin(line7_port_select, cands_line7);
      event_d[8]  = select_pin(line8_port_select, cands_line8);
      event_d[9]  = select_pin(line9_port_select, cands_line9);
      event_d[10] = select_pin(line10_port_select, cands_line10);
      event_d[11] = select_pin(line11_port_select, cands_line11);
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         event_q <= '0;
      end else begin
         event_q <= event_d;
      end
   end

   assign O_EVENT_LINE = event_q;

endmodule : ext_event_source_select

`default_nettype wire

// ==== rtl/ext_event_source_select_defs.svh ====
// Constants for the external event source selector: offsets, fields, resets, codes
`ifndef EXT_EVENT_SOURCE_SELECT_DEFS_SVH
`define EXT_EVENT_SOURCE_SELECT_DEFS_SVH

// ==========================================================================
// Bus geometry
`define EVSS_ADDR_WIDTH       8
`define EVSS_DATA_WIDTH       32

// ==========================================================================
// Register byte offsets
`define EVSS_OFS_LINES_0_3    8'h08
`define EVSS_OFS_LINES_4_7    8'h0C
`define EVSS_OFS_LINES_8_11   8'h10

// ==========================================================================
// Field layout
`define EVSS_SEL_WIDTH        4
`define EVSS_FIELDS_WIDTH     16
`define EVSS_NUM_SEL_REGS     3
`define EVSS_NUM_LINES        12
`define EVSS_NUM_PORTS        7
`define EVSS_RSVD_READ        16'h0000

// ==========================================================================
// Reset values
`define EVSS_SEL_RESET        16'h0000
`define EVSS_RDATA_RESET      32'h0000_0000

// ==========================================================================
// Selector codes
`define EVSS_CODE_PORT_A      4'h0
`define EVSS_CODE_PORT_B      4'h1
`define EVSS_CODE_PORT_C      4'h2
`define EVSS_CODE_PORT_D      4'h3
`define EVSS_CODE_PORT_E      4'h4
`define EVSS_CODE_PORT_F      4'h5
`define EVSS_CODE_PORT_G      4'h6

`endif

// ==== rtl/ext_event_source_select_pkg.sv ====
// Types shared by the external event source selector
`include "ext_event_source_select_defs.svh"

package ext_event_source_select_pkg;

   // =======================================================================
   // Pin and selector types
   typedef logic [`EVSS_SEL_WIDTH-1:0]   port_sel_t;
   typedef logic [`EVSS_NUM_LINES-1:0]   pin_group_t;
   typedef logic [`EVSS_NUM_PORTS-1:0]   pin_cands_t;
   typedef logic [`EVSS_ADDR_WIDTH-1:0]  bus_addr_t;
   typedef logic [`EVSS_DATA_WIDTH-1:0]  bus_data_t;

   // Input levels of ports A..G, pin n of each port at bit n
   typedef struct packed {
      pin_group_t port_g;
      pin_group_t port_f;
      pin_group_t port_e;
      pin_group_t port_d;
      pin_group_t port_c;
      pin_group_t port_b;
      pin_group_t port_a;
   } port_pins_s;

   // Four selector fields of one register, highest line first
   typedef struct packed {
      port_sel_t sel_hi;
      port_sel_t sel_mid_hi;
      port_sel_t sel_mid_lo;
      port_sel_t sel_lo;
   } sel_fields_s;

endpackage : ext_event_source_select_pkg

// ==== rtl/pin_level_sync.sv ====
// Two-stage synchroniser for the port pin levels
`timescale 1ns/100ps
`default_nettype none

module pin_level_sync
   import ext_event_source_select_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire port_pins_s i_pins,
   output var  port_pins_s o_pins
);

   port_pins_s meta_q;
   port_pins_s meta_d;
   port_pins_s stable_q;
   port_pins_s stable_d;

   // ========================================================================
   // First stage feeds only the second
   always_comb begin
      meta_d   = i_pins;
      stable_d = meta_q;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta_q   <= '0;
         stable_q <= '0;
      end else begin
         meta_q   <= meta_d;
         stable_q <= stable_d;
      end
   end

   assign o_pins = stable_q;

endmodule : pin_level_sync

`default_nettype wire

// ==== dv/evss_assertions.sv ====
// Port checker for the event source selector
`timescale 1ns/100ps
`default_nettype none
module evss_assertions
   import ext_event_source_select_pkg::*;
(
   input  wire logic       I_MCLK,
   input  wire logic       I_RST_B,
   input  wire bus_addr_t  I_ADDR,
   input  wire bus_data_t  I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   input  wire bus_data_t  O_RDATA,
   input  wire port_pins_s I_PORT_PINS,
   input  wire pin_group_t O_EVENT_LINE
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   // ==========================================================
   // Register port
   a_rd_idle_zero: assert property (!I_RD |=> O_RDATA == 32'h0000_0000)
      else $error("read data not zero");
   a_unmapped_rd: assert property (I_RD && !(I_ADDR inside {8'h08, 8'h0C, 8'h10})
      |=> O_RDATA == 32'h0000_0000) else $error("unmapped read not zero");
   a_upper_zero: assert property (I_RD |=> O_RDATA[31:16] == 16'h0000)
      else $error("upper half not zero");
   a_back_lines_0: assert property (I_WR && I_ADDR == 8'h08 ##1 !I_WR ##1 I_RD &&
      I_ADDR == 8'h08 |=> O_RDATA[15:0] == $past(I_WDATA[15:0], 3)) else $error("0x08");
   a_back_lines_4: assert property (I_WR && I_ADDR == 8'h0C ##1 !I_WR ##1 I_RD &&
      I_ADDR == 8'h0C |=> O_RDATA[15:0] == $past(I_WDATA[15:0], 3)) else $error("0x0C");
   a_back_lines_8: assert property (I_WR && I_ADDR == 8'h10 ##1 !I_WR ##1 I_RD &&
      I_ADDR == 8'h10 |=> O_RDATA[15:0] == $past(I_WDATA[15:0], 3)) else $error("0x10");
   // ==========================================================
   // Reset and event lines
   a_reset_zero: assert property ($rose(I_RST_B) |-> O_RDATA == 32'h0000_0000 &&
      O_EVENT_LINE == 12'h000) else $error("outputs not zero after reset");
   a_pins_low: assert property (I_PORT_PINS == '0 [*3] |=> O_EVENT_LINE == 12'h000)
      else $error("event line high with all pins low");
   cover property (I_WR ##2 I_RD);
   cover property ($rose(I_RST_B));
   cover property (O_EVENT_LINE == 12'hFFF);
endmodule : evss_assertions
`default_nettype wire

// ==== dv/port_pins_model.sv ====
// Port pins: the chosen port at a level, all others at the inverse; code 7 picks none
`timescale 1ns/100ps
`default_nettype none
module port_pins_model
   import ext_event_source_select_pkg::*;
(
   input  wire port_sel_t  i_port,
   input  wire logic       i_lvl,
   output var  port_pins_s o_pins
);
   logic [6:0][11:0] grp;
   always_comb begin
      for (int k = 0; k < 7; k++) begin
         grp[k] = (port_sel_t'(k) == i_port) ? {12{i_lvl}} : {12{~i_lvl}};
      end
      o_pins = port_pins_s'(grp);
   end
endmodule : port_pins_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Testbench for the event source selector
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import ext_event_source_select_pkg::*;
;
   logic       I_MCLK = 1'b0;
   logic       I_RST_B = 1'b0;
   bus_addr_t  I_ADDR = 8'h00;
   bus_data_t  I_WDATA = 32'h0000_0000;
   logic       I_WR = 1'b0;
   logic       I_RD = 1'b0;
   bus_data_t  O_RDATA;
   port_pins_s I_PORT_PINS;
   pin_group_t O_EVENT_LINE;
   port_sel_t  pin_port = 4'h7;
   logic       pin_lvl = 1'b0;
   pin_group_t exp_ev;
   int         num_errors = 0;
   int         n_tests = 0;
   always #50 I_MCLK = ~I_MCLK;
   ext_event_source_select dut (.I_MCLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
      .O_RDATA, .I_PORT_PINS, .O_EVENT_LINE);
   port_pins_model pins (.i_port(pin_port), .i_lvl(pin_lvl), .o_pins(I_PORT_PINS));
   task automatic chk(input bus_data_t got, input bus_data_t exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input bus_addr_t a, input bus_data_t d);
      @(posedge I_MCLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
   endtask : wr
   task automatic rd(input bus_addr_t a, input bus_data_t e);
      @(posedge I_MCLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      @(negedge I_MCLK);
      chk(O_RDATA, e);
   endtask : rd
   // Pins pass two sync flops and an output flop
   task automatic ev(input port_sel_t p, input logic l, input pin_group_t e);
      @(posedge I_MCLK);
      pin_port <= p;
      pin_lvl <= l;
      repeat (3) @(posedge I_MCLK);
      @(negedge I_MCLK);
      chk(bus_data_t'(O_EVENT_LINE), bus_data_t'(e));
   endtask : ev
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge I_MCLK);
      I_RST_B <= 1'b1;
      rd(8'h08, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      ev(4'h0, 1'b1, 12'hFFF);
      $display("reset test done");
      wr(8'h08, 32'h0000_3210);
      rd(8'h08, 32'h0000_3210);
      wr(8'h0C, 32'h0000_0654);
      rd(8'h0C, 32'h0000_0654);
      wr(8'h10, 32'h0000_4321);
      rd(8'h10, 32'h0000_4321);
      wr(8'h14, 32'h0000_FFFF);
      rd(8'h14, 32'h0000_0000);
      $display("register test done");
      for (int p = 0; p < 7; p++) begin
         for (int n = 0; n < 12; n++) begin
            exp_ev[n] = (n % 7 == p);
         end
         ev(port_sel_t'(p), 1'b1, exp_ev);
         ev(port_sel_t'(p), 1'b0, ~exp_ev);
      end
      ev(4'h7, 1'b1, 12'h000);
      ev(4'h7, 1'b0, 12'hFFF);
      $display("decode test done");
      @(posedge I_MCLK);
      I_RST_B <= 1'b0;
      repeat (3) @(posedge I_MCLK);
      I_RST_B <= 1'b1;
      rd(8'h08, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      ev(4'h0, 1'b1, 12'hFFF);
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule : tb_top
bind ext_event_source_select evss_assertions chk_i (.I_MCLK, .I_RST_B, .I_ADDR, .I_WDATA,
   .I_WR, .I_RD, .O_RDATA, .I_PORT_PINS, .O_EVENT_LINE);
`default_nettype wire
